// ==== verilog/ilec_pkg.sv ====
// ilec_pkg: constants and carrier types for the interrupt level and exception control block
// assumes one 50 MHz system clock, registers reached over axi4-lite at byte address = 4 * index
package ilec_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_LVL_0_3 = 16'h7f02;
    localparam logic [15:0] IDX_LVL_4_7 = 16'h7f03;
    localparam logic [15:0] IDX_LVL_8_11 = 16'h7f04;
    localparam logic [15:0] IDX_LVL_12_15 = 16'h7f05;
    localparam logic [15:0] IDX_EXC_LO = 16'h7f08;
    localparam logic [15:0] IDX_EXC_HI = 16'h7f09;

    // internal register selectors
    localparam logic [2:0] SEL_LVL0 = 3'h0;
    localparam logic [2:0] SEL_EXL = 3'h4;
    localparam logic [2:0] SEL_EXH = 3'h5;
    localparam logic [2:0] SEL_NONE = 3'h7;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int EXL_CLOCK_STOP_FLAG = 7;
    localparam int EXL_CLKSTP_EN = 6;
    localparam int EXL_ADDR_FLG = 5;
    localparam int EXL_ODD_FLG = 3;
    localparam int EXL_UNDEF_FLG = 1;
    localparam logic [7:0] EXL_FLAG_MASK = 8'haa;
    localparam logic [7:0] EXL_EN_MASK = 8'h55;
    localparam int EXH_SER0_FLG = 5;
    localparam int EXH_SER0_EN = 4;
    localparam int EXH_SER0_MASK = 2;
    localparam int PSW_IE_BIT = 7;
    localparam int PSW_IL_LSB = 8;
    localparam int PSW_WS_BIT = 11;

    // ------------------------------------------------------------
    // reset values, vectors, bus answers
    // ------------------------------------------------------------
    localparam logic [7:0] LVL_RST = 8'h00;
    localparam logic [7:0] EXL_RST = 8'h00;
    localparam logic [7:0] EXH_RST = 8'h00;
    localparam int NUM_VEC = 16;
    localparam int LVL_REGS = 4;
    localparam logic [15:0] VEC_BASE = 16'h8000;
    localparam logic [15:0] VEC_EXCEPTION = 16'h8080;
    localparam logic [1:0] EXC_LEVEL = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // request presented to the cpu core
    typedef struct packed {
        logic valid;
        logic exception;
        logic [1:0] level;
        logic [15:0] vector;
    } ilec_req_t;

    // one-cycle exception events reported by the cpu core
    typedef struct packed {
        logic address_fault;
        logic odd_word_access;
        logic undefined_opcode;
    } ilec_cpu_evt_t;

endpackage : ilec_pkg

// ==== verilog/ilec_top.sv ====
// ilec_top: interrupt level registers, exception control registers and request arbiter
// assumes cpu status word, cpu events and peripheral requests are on aclk; the
// oscillation stop detector output is asynchronous and is synchronised here
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ilec_top
    import ilec_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // cpu core
    input wire logic [15:0] cpu_status_word,
    input wire logic exception_in_service,
    input wire ilec_cpu_evt_t cpu_events,
    output ilec_req_t irq_request,
    // peripherals and clock monitor
    input wire logic [NUM_VEC-1:0] periph_req,
    input wire logic serial0_irq,
    input wire logic clock_stop_detect,
    output logic lowspeed_osc_en,
    output logic stop_detector_en
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] reg_sel(input logic [31:0] addr);
        logic [2:0] sel;
        sel = SEL_NONE;
        if (addr[1:0] == 2'h0 && addr[31:18] == 14'h0000) begin
            case (addr[17:2])
                IDX_LVL_0_3: sel = 3'h0;
                IDX_LVL_4_7: sel = 3'h1;
                IDX_LVL_8_11: sel = 3'h2;
                IDX_LVL_12_15: sel = 3'h3;
                IDX_EXC_LO: sel = SEL_EXL;
                IDX_EXC_HI: sel = SEL_EXH;
                default: sel = SEL_NONE;
            endcase
        end
        return sel;
    endfunction : reg_sel

    function automatic logic [1:0] lvl_decode(input logic [1:0] field);
        logic [1:0] lvl;
        case (field)
            2'b11: lvl = 2'd3;
            2'b10: lvl = 2'd2;
            2'b01: lvl = 2'd1;
            default: lvl = 2'd0;
        endcase
        return lvl;
    endfunction : lvl_decode

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic aw_have_r;
    logic w_have_r;
    logic [31:0] aw_addr_r;
    logic [7:0] w_data_r;
    logic w_strb0_r;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [7:0] lvl_r [LVL_REGS];
    logic [7:0] exl_r;
    logic [7:0] exl_nxt;
    logic ser0_en_r;
    logic ser0_mask_r;
    logic ser0_flag_r;
    logic stop_meta_r;
    logic stop_sync_r;
    logic osc_en_r;
    logic det_en_r;
    ilec_req_t req_r;
    ilec_req_t req_nxt;

    logic wr_fire;
    logic [2:0] wr_sel;
    logic exc_wr;
    logic [7:0] rd_byte;
    logic [2:0] rd_sel;
    logic ie;
    logic [2:0] cur_il;
    logic exc_any;
    logic [1:0] vec_lvl [NUM_VEC];
    logic [NUM_VEC-1:0] vec_elig;
    logic [1:0] best_lvl;
    logic [3:0] best_idx;

    assign ie = cpu_status_word[PSW_IE_BIT];
    assign cur_il = cpu_status_word[PSW_IL_LSB +: 3];
    assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
    assign wr_sel = reg_sel(aw_addr_r);
    assign exc_wr = wr_fire && w_strb0_r && cpu_status_word[PSW_WS_BIT];
    assign rd_sel = reg_sel(s_axi_araddr);

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            awready_r <= 1'b0;
            aw_addr_r <= 32'h0000_0000;
        end else if (s_axi_awvalid && awready_r) begin
            aw_have_r <= 1'b1;
            awready_r <= 1'b0;
            aw_addr_r <= s_axi_awaddr;
        end else begin
            if (wr_fire) begin
                aw_have_r <= 1'b0;
            end
            awready_r <= !aw_have_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_r <= 1'b0;
            wready_r <= 1'b0;
            w_data_r <= 8'h00;
            w_strb0_r <= 1'b0;
        end else if (s_axi_wvalid && wready_r) begin
            w_have_r <= 1'b1;
            wready_r <= 1'b0;
            w_data_r <= s_axi_wdata[7:0];
            w_strb0_r <= s_axi_wstrb[0];
        end else begin
            if (wr_fire) begin
                w_have_r <= 1'b0;
            end
            wready_r <= !w_have_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= (wr_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    always_comb begin
        rd_byte = 8'h00;
        case (rd_sel)
            3'h0, 3'h1, 3'h2, 3'h3: rd_byte = lvl_r[rd_sel[1:0]];
            SEL_EXL: rd_byte = exl_r;
            SEL_EXH: rd_byte = {2'b00, ser0_flag_r, ser0_en_r, 1'b0, ser0_mask_r, 2'b00};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= {24'h00_0000, rd_byte};
            rresp_r <= (rd_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
        end else begin
            if (rvalid_r && s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
            arready_r <= !rvalid_r;
        end
    end

    // ------------------------------------------------------------
    // level registers
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < LVL_REGS; gi++) begin : g_lvl
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    lvl_r[gi] <= LVL_RST;
                end else if (wr_fire && w_strb0_r && wr_sel == 3'(gi)) begin
                    lvl_r[gi] <= w_data_r;
                end
            end
        end
        for (gi = 0; gi < NUM_VEC; gi++) begin : g_vec
            // vector 4*k+j sits in register k, bit pair 2j+1:2j
            assign vec_lvl[gi] = lvl_decode(lvl_r[gi / 4][2 * (gi % 4) +: 2]);
            assign vec_elig[gi] = periph_req[gi] && vec_lvl[gi] != 2'd0 && ie
                && ({1'b0, vec_lvl[gi]} > cur_il) && !exception_in_service;
        end
    endgenerate

    // ------------------------------------------------------------
    // exception control registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stop_meta_r <= 1'b0;
            stop_sync_r <= 1'b0;
        end else begin
            stop_meta_r <= clock_stop_detect;
            stop_sync_r <= stop_meta_r;
        end
    end

    always_comb begin
        exl_nxt = exl_r;
        if (exc_wr && wr_sel == SEL_EXL) begin
            // writing 1 to a flag keeps it, writing 0 clears it
            exl_nxt = (w_data_r & EXL_EN_MASK) | (exl_r & w_data_r & EXL_FLAG_MASK);
        end
        // setting wins over a clear in the same cycle
        if (stop_sync_r && exl_r[EXL_CLKSTP_EN]) begin
            exl_nxt[EXL_CLOCK_STOP_FLAG] = 1'b1;
        end
        if (cpu_events.address_fault) begin
            exl_nxt[EXL_ADDR_FLG] = 1'b1;
        end
        if (cpu_events.odd_word_access) begin
            exl_nxt[EXL_ODD_FLG] = 1'b1;
        end
        if (cpu_events.undefined_opcode) begin
            exl_nxt[EXL_UNDEF_FLG] = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            exl_r <= EXL_RST;
        end else begin
            exl_r <= exl_nxt;
        end
    end

    // reserved high bits are not stored and read as zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ser0_en_r <= EXH_RST[EXH_SER0_EN];
            ser0_mask_r <= EXH_RST[EXH_SER0_MASK];
        end else if (exc_wr && wr_sel == SEL_EXH) begin
            ser0_en_r <= w_data_r[EXH_SER0_EN];
            ser0_mask_r <= w_data_r[EXH_SER0_MASK];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ser0_flag_r <= EXH_RST[EXH_SER0_FLG];
        end else begin
            ser0_flag_r <= serial0_irq;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_en_r <= 1'b0;
            det_en_r <= 1'b0;
        end else begin
            osc_en_r <= exl_r[EXL_CLKSTP_EN];
            det_en_r <= exl_r[EXL_CLKSTP_EN];
        end
    end

    // ------------------------------------------------------------
    // request arbitration
    // ------------------------------------------------------------
    assign exc_any = |(exl_r & (exl_r >> 1) & EXL_EN_MASK)
        || (ser0_flag_r && ser0_en_r && (ser0_mask_r ? ie : 1'b1));

    always_comb begin
        best_lvl = 2'd0;
        best_idx = 4'd0;
        // strict compare keeps the lowest vector among equal levels
        for (int i = 0; i < NUM_VEC; i++) begin
            if (vec_elig[i] && vec_lvl[i] > best_lvl) begin
                best_lvl = vec_lvl[i];
                best_idx = 4'(i);
            end
        end
    end

    always_comb begin
        req_nxt = '0;
        if (exc_any) begin
            req_nxt.valid = 1'b1;
            req_nxt.exception = 1'b1;
            req_nxt.level = EXC_LEVEL;
            req_nxt.vector = VEC_EXCEPTION;
        end else if (best_lvl != 2'd0) begin
            req_nxt.valid = 1'b1;
            req_nxt.level = best_lvl;
            req_nxt.vector = VEC_BASE + 16'({best_idx, 2'b00});
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_r <= '0;
        end else begin
            req_r <= req_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign irq_request = req_r;
    assign lowspeed_osc_en = osc_en_r;
    assign stop_detector_en = det_en_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    logic calm;
    assign calm = ie && cur_il == 3'd0 && !exception_in_service && !exc_any;

    a_disabled_vector: assert property (@(posedge aclk) disable iff (!aresetn)
        (calm && periph_req == 16'h0001 && lvl_r[0][1:0] == 2'b00) |=> !irq_request.valid)
        else $error("disabled vector produced a request");
    a_map_first_low: assert property (@(posedge aclk) disable iff (!aresetn)
        (calm && periph_req == 16'h0008 && lvl_r[0][7:6] == 2'b10)
        |=> irq_request.valid && irq_request.vector == 16'h800c && irq_request.level == 2'd2)
        else $error("vector 800C not taken from bits 7:6");
    a_map_first_high: assert property (@(posedge aclk) disable iff (!aresetn)
        (calm && periph_req == 16'h0010 && lvl_r[1][1:0] == 2'b11)
        |=> irq_request.vector == 16'h8010 && irq_request.level == 2'd3)
        else $error("vector 8010 not taken from bits 1:0");
    a_map_second_low: assert property (@(posedge aclk) disable iff (!aresetn)
        (calm && periph_req == 16'h0200 && lvl_r[2][3:2] == 2'b01)
        |=> irq_request.vector == 16'h8024 && irq_request.level == 2'd1)
        else $error("vector 8024 not taken from bits 3:2");
    a_map_second_high: assert property (@(posedge aclk) disable iff (!aresetn)
        (calm && periph_req == 16'h8000 && lvl_r[3][7:6] == 2'b11)
        |=> irq_request.vector == 16'h803c)
        else $error("vector 803C not taken from bits 7:6");
    a_write_permit: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && !cpu_status_word[PSW_WS_BIT])
        |=> $stable(exl_r & EXL_EN_MASK) && $stable(ser0_en_r) && $stable(ser0_mask_r))
        else $error("exception register written without permit");
    a_clkstop_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        (stop_sync_r && exl_r[EXL_CLKSTP_EN]) |=> exl_r[EXL_CLOCK_STOP_FLAG])
        else $error("clock stop flag not set");
    a_osc_enable: assert property (@(posedge aclk) disable iff (!aresetn)
        exl_r[EXL_CLKSTP_EN] |=> lowspeed_osc_en && stop_detector_en)
        else $error("oscillator or detector not enabled");
    a_addr_fault: assert property (@(posedge aclk) disable iff (!aresetn)
        cpu_events.address_fault |=> exl_r[EXL_ADDR_FLG])
        else $error("address fault flag not set");
    a_odd_access: assert property (@(posedge aclk) disable iff (!aresetn)
        cpu_events.odd_word_access |=> exl_r[EXL_ODD_FLG])
        else $error("odd access flag not set");
    a_undef_opcode: assert property (@(posedge aclk) disable iff (!aresetn)
        cpu_events.undefined_opcode |=> exl_r[EXL_UNDEF_FLG])
        else $error("undefined opcode flag not set");
    a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        (exl_r[EXL_ADDR_FLG] && !(exc_wr && wr_sel == SEL_EXL)) |=> exl_r[EXL_ADDR_FLG])
        else $error("exception flag cleared by itself");
    a_exc_vector: assert property (@(posedge aclk) disable iff (!aresetn)
        (exl_r[EXL_UNDEF_FLG] && exl_r[0])
        |=> irq_request.valid && irq_request.exception && irq_request.vector == 16'h8080)
        else $error("exception vector not requested");
    a_serial_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> ser0_flag_r == $past(serial0_irq))
        else $error("serial flag does not follow its source");
    a_serial_masked: assert property (@(posedge aclk) disable iff (!aresetn)
        (ser0_flag_r && ser0_en_r && ser0_mask_r && !ie && (exl_r & (exl_r >> 1) & EXL_EN_MASK) == 8'h00)
        |=> !irq_request.exception)
        else $error("masked serial exception passed");
    a_serial_unmasked: assert property (@(posedge aclk) disable iff (!aresetn)
        (ser0_flag_r && ser0_en_r && !ser0_mask_r) |=> irq_request.exception)
        else $error("unmasked serial exception lost");
    a_equal_level_tie: assert property (@(posedge aclk) disable iff (!aresetn)
        (calm && periph_req == 16'h000a && lvl_r[0][3:2] == lvl_r[0][7:6] && lvl_r[0][3:2] != 2'b00)
        |=> irq_request.vector == 16'h8004)
        else $error("tie not resolved to lowest vector");
    a_level_above: assert property (@(posedge aclk) disable iff (!aresetn)
        (irq_request.valid && !irq_request.exception)
        |-> {1'b0, irq_request.level} > $past(cur_il) && $past(ie))
        else $error("request not above current level");
    a_exc_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
        (exception_in_service && !exc_any) |=> !irq_request.valid)
        else $error("peripheral request during exception service");

endmodule : ilec_top

// ==== test/ilec_cpu_model.sv ====
// cpu core stand-in: registered status word and one-cycle exception events
// assumes the bench drives its commands on aclk
`timescale 1ns/1ps
module ilec_cpu_model import ilec_pkg::*; (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // commands from the bench
    input wire logic [15:0] psw_cmd,
    input wire ilec_cpu_evt_t evt_cmd,
    input wire logic evt_go,
    // cpu side of the block
    output logic [15:0] cpu_status_word,
    output ilec_cpu_evt_t cpu_events
);
    always_ff @(posedge aclk) begin
        cpu_status_word <= aresetn ? psw_cmd : 16'h0000;
    end
    always_ff @(posedge aclk) begin
        cpu_events <= (aresetn && evt_go) ? evt_cmd : '0;
    end
endmodule : ilec_cpu_model

// ==== test/interrupt_level_and_exception_control_tb.sv ====
// bench: axi4-lite master, cpu model, request checks
// assumes ilec_pkg, ilec_top and ilec_cpu_model compiled first
`timescale 1ns/1ps
module interrupt_level_and_exception_control_tb import ilec_pkg::*;;
logic aclk = 1'b0, aresetn = 1'b0;
logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic [15:0] psw_cmd = '0, periph_req = '0, cpu_status_word;
logic exception_in_service = 1'b0, serial0_irq = 1'b0, clock_stop_detect = 1'b0, evt_go = 1'b0;
logic [3:0] s_axi_wstrb = 4'h1;
logic lowspeed_osc_en, stop_detector_en;
ilec_cpu_evt_t evt_cmd = '0, cpu_events;
ilec_req_t irq_request;
localparam ilec_req_t EXC_REQ = {1'b1, 1'b1, EXC_LEVEL, VEC_EXCEPTION};
logic [7:0] lr [4];
logic [33:0] exp_q [$];
int num_errors = 0, total_checks = 0;
always #10 aclk = ~aclk;
ilec_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cpu_status_word, .exception_in_service, .cpu_events, .irq_request, .periph_req,
    .serial0_irq, .clock_stop_detect, .lowspeed_osc_en, .stop_detector_en);
ilec_cpu_model i_cpu (.aclk, .aresetn, .psw_cmd, .evt_cmd, .evt_go, .cpu_status_word, .cpu_events);
task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    total_checks++;
    if (g !== e) begin
        num_errors++;
        $display("[ERR] %s exp %h got %h", n, e, g);
    end
endtask : chk
task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= {14'h0000, idx, 2'h0};
    s_axi_wdata <= {24'h00_0000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(aw && w)) begin
        @(posedge aclk);
        aw = aw | s_axi_awready;
        w = w | s_axi_wready;
        s_axi_awvalid <= !aw;
        s_axi_wvalid <= !w;
    end
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk("bresp", RESP_OKAY, s_axi_bresp);
    @(posedge aclk);
endtask : wr
// expected read is queued here and compared by the monitor below
task automatic rd(input logic [15:0] idx, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
    exp_q.push_back({er, 24'h00_0000, e});
    s_axi_araddr <= {14'h0000, idx, 2'h0};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
endtask : rd
always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) chk("rdata", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
end
task automatic irq_chk(input ilec_req_t e);
    repeat (5) @(posedge aclk);
    chk("irq_request", e, irq_request);
endtask : irq_chk
// highest level wins, lowest vector among equals, only above current level
function automatic ilec_req_t best(input logic [15:0] req, input logic [2:0] cur);
    ilec_req_t r;
    r = '0;
    for (int l = 1; l < 4; l++) begin
        for (int v = 15; v >= 0; v--) begin
            if (req[v] && lr[v / 4][2 * (v % 4) +: 2] == l && l > cur) r = {2'h2, 2'(l), VEC_BASE + 16'(4 * v)};
        end
    end
    return r;
endfunction : best
task automatic end_of_test;
    if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask : end_of_test
initial begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    end_of_test();
end
initial begin
    void'($urandom(58));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 6; k++) rd(k < 4 ? IDX_LVL_0_3 + 16'(k) : IDX_EXC_LO + 16'(k - 4), 8'h00);
    rd(16'h7f06, 8'h00, RESP_DECERR);
    psw_cmd <= 16'h0080;
    for (int k = 0; k < 4; k++) begin
        // random fields, a few pinned so every mapping check and the equal-level tie are reached
        lr[k] = 8'($urandom);
        case (k)
            0: lr[k] = 8'h98;
            1: lr[k][1:0] = 2'b11;
            2: lr[k][3:2] = 2'b01;
            default: lr[k][7:6] = 2'b11;
        endcase
        wr(IDX_LVL_0_3 + 16'(k), lr[k]);
        rd(IDX_LVL_0_3 + 16'(k), lr[k]);
    end
    // a write without byte lane 0 must leave the register alone
    s_axi_wstrb <= 4'h0;
    wr(IDX_LVL_0_3, 8'hff);
    s_axi_wstrb <= 4'h1;
    rd(IDX_LVL_0_3, lr[0]);
    for (int v = 0; v < 16; v++) begin
        periph_req <= 16'(1 << v);
        irq_chk(best(16'(1 << v), 3'h0));
    end
    periph_req <= 16'h000a;
    irq_chk(best(16'h000a, 3'h0));
    periph_req <= 16'hffff;
    for (int c = 0; c < 4; c++) begin
        psw_cmd <= {5'h00, 3'(c), 8'h80};
        irq_chk(best(16'hffff, 3'(c)));
    end
    psw_cmd <= 16'h0000;
    irq_chk('0);
    psw_cmd <= 16'h0080;
    exception_in_service <= 1'b1;
    irq_chk('0);
    exception_in_service <= 1'b0;
    wr(IDX_EXC_LO, 8'h55);
    rd(IDX_EXC_LO, 8'h00);
    psw_cmd <= 16'h0880;
    wr(IDX_EXC_LO, 8'h15);
    evt_cmd <= '1;
    evt_go <= 1'b1;
    @(posedge aclk);
    evt_go <= 1'b0;
    irq_chk(EXC_REQ);
    rd(IDX_EXC_LO, 8'h3f);
    wr(IDX_EXC_LO, 8'h15);
    irq_chk(best(16'hffff, 3'h0));
    wr(IDX_EXC_LO, 8'h40);
    chk("osc_en", 2'h3, {lowspeed_osc_en, stop_detector_en});
    clock_stop_detect <= 1'b1;
    irq_chk(EXC_REQ);
    clock_stop_detect <= 1'b0;
    rd(IDX_EXC_LO, 8'hc0);
    wr(IDX_EXC_LO, 8'h00);
    chk("osc_en", 2'h0, {lowspeed_osc_en, stop_detector_en});
    periph_req <= 16'h0000;
    serial0_irq <= 1'b1;
    psw_cmd <= 16'h0800;
    wr(IDX_EXC_HI, 8'h14);
    rd(IDX_EXC_HI, 8'h34);
    irq_chk('0);
    wr(IDX_EXC_HI, 8'h30);
    irq_chk(EXC_REQ);
    serial0_irq <= 1'b0;
    repeat (2) @(posedge aclk);
    rd(IDX_EXC_HI, 8'h10);
    end_of_test();
end
endmodule : interrupt_level_and_exception_control_tb
